// ==== hdl/lpv_map.vh ====
`ifndef LPV_MAP_VH
`define LPV_MAP_VH
// Register offsets on the configuration port
`define LPV_OFS_LOAD_SYNC   8'h0e
`define LPV_OFS_STATUS      8'h0f
`define LPV_OFS_PAT_CFG     8'h10
`define LPV_OFS_CP_LOW      8'h11
`define LPV_OFS_CP_MID      8'h12
`define LPV_OFS_CP_HIGH     8'h13
`define LPV_OFS_THRESHOLD   8'h14
`define LPV_OFS_TEST_CTRL   8'h15
`define LPV_OFS_DP_ENABLE   8'h16
`define LPV_OFS_FLAGS       8'h17
`define LPV_OFS_CNT_BASE    8'h18
// Field positions
`define LPV_CP20_BIT        7
`define LPV_LEN_MSB         5
`define LPV_LEN_LSB         3
`define LPV_SEL_MSB         2
`define LPV_SEL_LSB         0
`define LPV_DESKEW_BIT      7
`define LPV_CNT_CLR_BIT     4
`define LPV_FLAG_CLR_BIT    3
// Pattern select codes
`define LPV_SEL_OFF         3'h0
`define LPV_SEL_PRBS        3'h1
`define LPV_SEL_CLOCK       3'h2
`define LPV_SEL_CUSTOM      3'h3
// Datapath test select codes
`define LPV_DP_DATA_ERR     3'h0
`define LPV_DP_BUF_ERR      3'h1
`define LPV_DP_BUF_UNDER    3'h3
`define LPV_DP_DESKEW       3'h4
// Sync pulse width in unit intervals, one UI per clock here
`define LPV_SYNC_UI         4'h8
// Reset values
`define LPV_RST_BYTE        8'h00
`endif

// ==== hdl/lpv_prbs_lane.v ====
`timescale 1ns/1ns
`include "lpv_map.vh"
// One receive lane: settings latch, pattern reference, compare, sync pulse
module lpv_prbs_lane (
    input  wire        clk,          // Device clock
    input  wire        srst,         // Sync reset, high
    input  wire        load,         // Lane load bit
    input  wire [2:0]  cfg_sel,      // Live pattern select
    input  wire [2:0]  cfg_len,      // Live sequence length
    input  wire        cfg_cp20,     // Live custom length
    input  wire [19:0] cfg_cp,       // Live custom pattern
    input  wire [2:0]  cfg_to,       // Live timeout
    input  wire        rx_bit,       // Received serial bit
    output reg         mismatch_ff,  // Mismatch pulse
    output reg         search_ff,    // Searching for pattern
    output reg         sync_ff       // Sync pulse
);
    reg  [2:0]  sel_ff;
    reg  [2:0]  len_ff;
    reg         cp20_ff;
    reg  [19:0] cp_ff;
    reg  [2:0]  to_ff;
    reg  [30:0] lfsr_ff;
    reg  [31:0] pos_ff;
    reg  [4:0]  cpos_ff;
    reg  [3:0]  pw_ff;
    reg  [2:0]  good_ff;
    reg         ph_ff;
    reg  [4:0]  tap;
    wire [2:0]  sel  = load ? cfg_sel  : sel_ff;
    wire [2:0]  len  = load ? cfg_len  : len_ff;
    wire        cp20 = load ? cfg_cp20 : cp20_ff;
    wire [19:0] cp   = load ? cfg_cp   : cp_ff;
    wire [2:0]  tmo  = load ? cfg_to   : to_ff;
    reg  [4:0]  order;
    reg         fb;
    reg  [31:0] period;
    reg         expect_bit;
    wire [4:0]  cp_last = cp20 ? 5'h13 : 5'h0f;
    // Polynomial order from the length code
    always @* begin
        case (len)
            3'h0: order = 5'd7;
            3'h1: order = 5'd11;
            3'h2: order = 5'd23;
            3'h3: order = 5'd31;
            3'h4, 3'h5: order = 5'd15;
            default: order = 5'd20;
        endcase
        // Second feedback tap of each polynomial
        case (len)
            3'h0: tap = 5'd6;
            3'h1: tap = 5'd9;
            3'h2: tap = 5'd18;
            3'h3: tap = 5'd28;
            3'h4, 3'h5: tap = 5'd14;
            default: tap = 5'd3;
        endcase
        fb = lfsr_ff[order - 5'd1] ^ lfsr_ff[tap - 5'd1];
        period = (32'h1 << order) - 32'h1;
        case (sel)
            `LPV_SEL_PRBS:   expect_bit = fb;
            `LPV_SEL_CLOCK:  expect_bit = ph_ff;
            `LPV_SEL_CUSTOM: expect_bit = cp[cpos_ff];
            default:         expect_bit = rx_bit;
        endcase
    end
    // Settings follow while loading, held once load drops
    always @(posedge clk) begin
        if (srst) begin
            sel_ff <= 3'h0;
            len_ff <= 3'h0;
            cp20_ff <= 1'b0;
            cp_ff <= 20'h00000;
            to_ff <= 3'h0;
        end else if (load) begin
            sel_ff <= cfg_sel;
            len_ff <= cfg_len;
            cp20_ff <= cfg_cp20;
            cp_ff <= cfg_cp;
            to_ff <= cfg_to;
        end
    end
    // Reference generators and comparator; search ends after a clean run
    always @(posedge clk) begin
        if (srst || load || sel == `LPV_SEL_OFF) begin
            lfsr_ff <= 31'h7fffffff;
            pos_ff <= 32'h0;
            cpos_ff <= 5'h0;
            ph_ff <= 1'b0;
            pw_ff <= 4'h0;
            good_ff <= 3'h0;
            mismatch_ff <= 1'b0;
            search_ff <= ~srst & (sel != `LPV_SEL_OFF);
            sync_ff <= 1'b0;
        end else begin
            // While searching, seed from the line so the generator locks
            lfsr_ff <= {lfsr_ff[29:0], search_ff ? rx_bit : fb};
            pos_ff <= (pos_ff >= period - 32'h1) ? 32'h0 : pos_ff + 32'h1;
            // A miss during search slips clock and custom phase by one bit
            if (!(search_ff && expect_bit != rx_bit)) begin
                ph_ff <= ~ph_ff;
                cpos_ff <= (cpos_ff == cp_last) ? 5'h0 : cpos_ff + 5'h1;
            end
            // 8 UI wide pulse once per generator period
            if (pos_ff == 32'h0)
                pw_ff <= `LPV_SYNC_UI;
            else if (pw_ff != 4'h0)
                pw_ff <= pw_ff - 4'h1;
            sync_ff <= (pos_ff == 32'h0) | (pw_ff > 4'h1);
            mismatch_ff <= ~search_ff & (expect_bit != rx_bit);
            // Search clears after timeout+1 matching bits
            if (search_ff) begin
                if (expect_bit != rx_bit)
                    good_ff <= 3'h0;
                else if (good_ff == tmo)
                    search_ff <= 1'b0;
                else
                    good_ff <= good_ff + 3'h1;
            end
        end
    end
endmodule

// ==== hdl/lpv_err_counter.v ====
`timescale 1ns/1ns
// 12-bit saturating error counter with clear
module lpv_err_counter (
    input  wire        clk,       // Device clock
    input  wire        srst,      // Sync reset, high
    input  wire        clr,       // One-cycle clear
    input  wire        inc,       // Count one error
    output reg  [11:0] count_ff   // Current count
);
    // Saturate rather than wrap so overflow is never mistaken for few errors
    always @(posedge clk) begin
        if (srst || clr)
            count_ff <= 12'h000;
        else if (inc && count_ff != 12'hfff)
            count_ff <= count_ff + 12'h001;
    end
endmodule

// ==== hdl/lpv_verifier.v ====
`timescale 1ns/1ns
`include "lpv_map.vh"
// Summary of operation
// - Each lane's sync bit pulses 8 UI once per generator period.
// - While load is high, current settings drive the lane.
// - When load falls, settings are latched until next load.
// - Lane mismatch flag rises on received data differing from expected.
// - Search bit is high while lane is still acquiring the pattern.
// - Custom length bit: 0 selects 16 bits, 1 selects 20.
// - Length code picks order 7, 11, 23, 31, 15 or 20.
// - Select: off, pseudo-random, clock, custom, or timing-only.
// - Custom bits 19:16 used only in 20-bit mode.
// - Deskew-done status bit reads high after lane deskew.
// - Counters clear on rising edge of the clear bit only.
// - Writing the flag clear bit clears latched flags; self-clearing.
// - 3-bit field selects the test flag source.
// - 4-bit enable chooses which lane datapaths are verified.
// - Datapath select chooses data, buffer, underflow or deskew report.
// - One live and one latched test flag per lane.
// - 12-bit error counter per lane, read as low byte and nibble.
module lpv_verifier (
    input  wire       clk,          // Device clock, 20 MHz
    input  wire       srst,         // Sync reset, high
    input  wire       cfg_wr,       // Register write strobe
    input  wire       cfg_rd,       // Register read strobe
    input  wire [7:0] cfg_addr,     // Register offset
    input  wire [7:0] cfg_wdata,    // Write data
    output reg  [7:0] cfg_rdata_ff, // Read data
    input  wire [3:0] rx_bit,       // Received serial bit per lane
    input  wire [3:0] data_err,     // Disparity or data error per lane
    input  wire [3:0] buf_err,      // Buffer error per lane
    input  wire [3:0] buf_under,    // Buffer underflow per lane
    input  wire       deskew_in,    // Lane deskew complete
    output reg  [3:0] lane_cfg_ff,  // Loaded lanes, for datapath use
    output reg  [2:0] threshold_ff  // Retain threshold to receivers
);
    reg  [3:0]  load_ff;
    reg  [2:0]  sel_ff;
    reg  [2:0]  len_ff;
    reg         cp20_ff;
    reg  [19:0] cp_ff;
    reg  [2:0]  irq_src_ff;
    reg  [3:0]  dp_en_ff;
    reg  [2:0]  dp_sel_ff;
    reg         clr_lvl_ff;
    reg         clr_prev_ff;
    reg         flag_clr_ff;
    reg         deskew_ff;
    reg  [3:0]  live_ff;
    reg  [3:0]  latched_ff;
    reg  [7:0]  nxt_rdata;
    reg  [3:0]  event_vec;
    wire [3:0]  mismatch;
    wire [3:0]  search;
    wire [3:0]  sync;
    wire [11:0] cnt [0:3];
    wire        cnt_clr = clr_lvl_ff & ~clr_prev_ff;
    wire [3:0]  nxt_live;
    genvar g;

    // Per-lane verifier and error counter
    generate
        for (g = 0; g < 4; g = g + 1) begin : lane
            lpv_prbs_lane u_lane (
                .clk         (clk),
                .srst        (srst),
                .load        (load_ff[g]),
                .cfg_sel     (sel_ff),
                .cfg_len     (len_ff),
                .cfg_cp20    (cp20_ff),
                .cfg_cp      (cp_ff),
                .cfg_to      (threshold_ff),
                .rx_bit      (rx_bit[g]),
                .mismatch_ff (mismatch[g]),
                .search_ff   (search[g]),
                .sync_ff     (sync[g])
            );
            lpv_err_counter u_cnt (
                .clk      (clk),
                .srst     (srst),
                .clr      (cnt_clr),
                .inc      (nxt_live[g]),
                .count_ff (cnt[g])
            );
        end
    endgenerate

    // Datapath event chosen by test select, gated per lane
    always @* begin
        case (dp_sel_ff)
            `LPV_DP_DATA_ERR:  event_vec = data_err;
            `LPV_DP_BUF_ERR:   event_vec = buf_err;
            `LPV_DP_BUF_UNDER: event_vec = buf_under;
            `LPV_DP_DESKEW:    event_vec = {4{deskew_ff}};
            default:           event_vec = 4'h0;
        endcase
    end
    // Source 0 is the datapath, 1 lane mismatch, 2 lane search; sources 3 to 7 give no events
    assign nxt_live = (irq_src_ff == 3'h0) ? (event_vec & dp_en_ff) :
                      (irq_src_ff == 3'h1) ? mismatch :
                      (irq_src_ff == 3'h2) ? search : 4'h0;

    // Register writes; the flag clear bit is a one-shot strobe, the counter clear bit is held as a level
    always @(posedge clk) begin
        if (srst) begin
            load_ff <= 4'h0;
            sel_ff <= 3'h0;
            len_ff <= 3'h0;
            cp20_ff <= 1'b0;
            cp_ff <= 20'h00000;
            threshold_ff <= 3'h0;
            irq_src_ff <= 3'h0;
            dp_en_ff <= 4'h0;
            dp_sel_ff <= 3'h0;
            clr_lvl_ff <= 1'b0;
            flag_clr_ff <= 1'b0;
        end else begin
            flag_clr_ff <= 1'b0;
            if (cfg_wr) begin
                case (cfg_addr)
                    `LPV_OFS_LOAD_SYNC: load_ff <= cfg_wdata[3:0];
                    `LPV_OFS_PAT_CFG: begin
                        cp20_ff <= cfg_wdata[`LPV_CP20_BIT];
                        len_ff <= cfg_wdata[`LPV_LEN_MSB:`LPV_LEN_LSB];
                        sel_ff <= cfg_wdata[`LPV_SEL_MSB:`LPV_SEL_LSB];
                    end
                    `LPV_OFS_CP_LOW:  cp_ff[7:0] <= cfg_wdata;
                    `LPV_OFS_CP_MID:  cp_ff[15:8] <= cfg_wdata;
                    `LPV_OFS_CP_HIGH: cp_ff[19:16] <= cfg_wdata[3:0];
                    `LPV_OFS_THRESHOLD: threshold_ff <= cfg_wdata[2:0];
                    `LPV_OFS_TEST_CTRL: begin
                        clr_lvl_ff <= cfg_wdata[`LPV_CNT_CLR_BIT];
                        flag_clr_ff <= cfg_wdata[`LPV_FLAG_CLR_BIT];
                        irq_src_ff <= cfg_wdata[2:0];
                    end
                    `LPV_OFS_DP_ENABLE: begin
                        dp_en_ff <= cfg_wdata[7:4];
                        dp_sel_ff <= cfg_wdata[2:0];
                    end
                    default: ;
                endcase
            end
        end
    end

    // Edge detect on clear level, deskew capture, flags
    always @(posedge clk) begin
        if (srst) begin
            clr_prev_ff <= 1'b0;
            deskew_ff <= 1'b0;
            live_ff <= 4'h0;
            latched_ff <= 4'h0;
            lane_cfg_ff <= 4'h0;
        end else begin
            clr_prev_ff <= clr_lvl_ff;
            deskew_ff <= deskew_in;
            live_ff <= nxt_live;
            lane_cfg_ff <= load_ff;
            // A new event in the clear cycle wins over the clear
            latched_ff <= (flag_clr_ff ? 4'h0 : latched_ff) | live_ff;
        end
    end

    // Read mux, status reflects live block state
    always @* begin
        nxt_rdata = 8'h00;
        case (cfg_addr)
            `LPV_OFS_LOAD_SYNC: nxt_rdata = {sync, load_ff};
            `LPV_OFS_STATUS:    nxt_rdata = {mismatch, search};
            `LPV_OFS_PAT_CFG:   nxt_rdata = {cp20_ff, 1'b0, len_ff, sel_ff};
            `LPV_OFS_CP_LOW:    nxt_rdata = cp_ff[7:0];
            `LPV_OFS_CP_MID:    nxt_rdata = cp_ff[15:8];
            `LPV_OFS_CP_HIGH:   nxt_rdata = {4'h0, cp_ff[19:16]};
            `LPV_OFS_THRESHOLD: nxt_rdata = {5'h00, threshold_ff};
            `LPV_OFS_TEST_CTRL:
                nxt_rdata = {deskew_ff, 2'b00, clr_lvl_ff, 1'b0, irq_src_ff};
            `LPV_OFS_DP_ENABLE: nxt_rdata = {dp_en_ff, 1'b0, dp_sel_ff};
            `LPV_OFS_FLAGS:     nxt_rdata = {latched_ff, live_ff};
            8'h18: nxt_rdata = cnt[0][7:0];
            8'h19: nxt_rdata = {4'h0, cnt[0][11:8]};
            8'h1a: nxt_rdata = cnt[1][7:0];
            8'h1b: nxt_rdata = {4'h0, cnt[1][11:8]};
            8'h1c: nxt_rdata = cnt[2][7:0];
            8'h1d: nxt_rdata = {4'h0, cnt[2][11:8]};
            8'h1e: nxt_rdata = cnt[3][7:0];
            8'h1f: nxt_rdata = {4'h0, cnt[3][11:8]};
            default: nxt_rdata = `LPV_RST_BYTE;
        endcase
    end

    // Registered read data
    always @(posedge clk) begin
        if (srst)
            cfg_rdata_ff <= `LPV_RST_BYTE;
        else if (cfg_rd)
            cfg_rdata_ff <= nxt_rdata;
    end
endmodule

// ==== sim/lpv_verifier_props.sv ====
`timescale 1ns/1ns
module lpv_verifier_props (
    input wire       clk,          // Device clock
    input wire       srst,         // Sync reset
    input wire       cfg_wr,       // Write strobe
    input wire       cfg_rd,       // Read strobe
    input wire [7:0] cfg_addr,     // Offset
    input wire [7:0] cfg_wdata,    // Write data
    input wire [7:0] cfg_rdata_ff, // Read data
    input wire       deskew_in,    // Deskew level
    input wire [3:0] lane_cfg_ff   // Loaded lanes
);
    reg  [7:0] sh_ff [0:31];
    integer    k;
    wire       rd_q;
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    // A write in the same cycle would make the shadow ambiguous
    assign rd_q = cfg_rd && !cfg_wr;
    // Shadow of written bytes; offsets above 0x1f alias, so guard them
    always @(posedge clk) begin
        if (srst) begin
            for (k = 0; k < 32; k = k + 1)
                sh_ff[k] <= 8'h00;
        end else if (cfg_wr && cfg_addr[7:5] == 3'h0) begin
            sh_ff[cfg_addr[4:0]] <= cfg_wdata;
        end
    end
    a_load_readback: assert property (
        rd_q && cfg_addr == 8'h0e |=> cfg_rdata_ff[3:0] == sh_ff[14][3:0])
        else $error("load bits readback differs");
    a_lane_cfg_copy: assert property (
        cfg_wr && cfg_addr == 8'h0e ##1 !cfg_wr ##1 1'b1
        |-> lane_cfg_ff == sh_ff[14][3:0])
        else $error("lane load copy differs");
    a_pat_cfg_back: assert property (
        rd_q && cfg_addr == 8'h10 |=> cfg_rdata_ff == (sh_ff[16] & 8'hbf))
        else $error("pattern config readback differs");
    a_cp_high_back: assert property (
        rd_q && cfg_addr == 8'h13 |=> cfg_rdata_ff == (sh_ff[19] & 8'h0f))
        else $error("custom high readback differs");
    a_test_ctrl_back: assert property (
        rd_q && cfg_addr == 8'h15
        |=> cfg_rdata_ff[4:0] == (sh_ff[21][4:0] & 5'h17))
        else $error("test control readback differs");
    a_dp_en_back: assert property (
        rd_q && cfg_addr == 8'h16 |=> cfg_rdata_ff == (sh_ff[22] & 8'hf7))
        else $error("datapath enable readback differs");
    a_cnt_nibble_only: assert property (
        cfg_rd && cfg_addr[7:3] == 5'h03 && cfg_addr[0]
        |=> cfg_rdata_ff[7:4] == 4'h0)
        else $error("counter upper byte not a nibble");
    a_deskew_seen: assert property (
        cfg_rd && cfg_addr == 8'h15 && deskew_in && $past(deskew_in)
        |=> cfg_rdata_ff[7])
        else $error("deskew done not reported");
    c_flag_latched: cover property (
        cfg_rd && cfg_addr == 8'h17 ##1 cfg_rdata_ff[4]);
    c_count_sat: cover property (
        cfg_rd && cfg_addr == 8'h1f ##1 cfg_rdata_ff == 8'h0f);
    c_deskew_high: cover property (
        cfg_rd && cfg_addr == 8'h15 ##1 cfg_rdata_ff[7]);
endmodule
bind lpv_verifier lpv_verifier_props i_props (.clk(clk), .srst(srst),
    .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr),
    .cfg_wdata(cfg_wdata), .cfg_rdata_ff(cfg_rdata_ff),
    .deskew_in(deskew_in), .lane_cfg_ff(lane_cfg_ff));

// ==== sim/lpv_verifier_tb.sv ====
`timescale 1ns/1ns
module lpv_verifier_tb;
    reg        clk = 1'b0;
    reg        srst = 1'b1;
    reg        cfg_wr = 1'b0;
    reg        cfg_rd = 1'b0;
    reg        tog = 1'b0;
    reg        deskew_in = 1'b0;
    reg  [7:0] cfg_addr = 8'h00;
    reg  [7:0] cfg_wdata = 8'h00;
    reg  [7:0] rd_v;
    reg  [3:0] rx_bit = 4'h0;
    reg  [3:0] data_err = 4'h0;
    reg  [3:0] buf_err = 4'h0;
    reg  [3:0] buf_under = 4'h0;
    wire [7:0] cfg_rdata_ff;
    wire [3:0] lane_cfg_ff;
    wire [2:0] threshold_ff;
    integer    err_count = 0;
    integer    checked = 0;
    integer    i;
    integer    n;
    // Clock, 50 ns period
    always #25 clk = ~clk;
    // Alternating lane data while enabled, stuck otherwise
    always @(posedge clk) if (tog) rx_bit <= ~rx_bit;
    lpv_verifier i_dut (.clk(clk), .srst(srst), .cfg_wr(cfg_wr),
        .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
        .cfg_rdata_ff(cfg_rdata_ff), .rx_bit(rx_bit), .data_err(data_err),
        .buf_err(buf_err), .buf_under(buf_under), .deskew_in(deskew_in),
        .lane_cfg_ff(lane_cfg_ff), .threshold_ff(threshold_ff));
    // Strobes drop for a cycle so no signal is assigned twice per step
    task wr(input [7:0] a, input [7:0] d);
        begin
            cfg_addr <= a;
            cfg_wdata <= d;
            cfg_wr <= 1'b1;
            @(posedge clk);
            cfg_wr <= 1'b0;
            @(posedge clk);
        end
    endtask
    task rd(input [7:0] a);
        begin
            cfg_addr <= a;
            cfg_rd <= 1'b1;
            @(posedge clk);
            cfg_rd <= 1'b0;
            @(posedge clk);
            rd_v = cfg_rdata_ff;
        end
    endtask
    task chk(input string nm, input [7:0] e, input [7:0] g);
        begin
            checked = checked + 1;
            if (g !== e) begin
                err_count = err_count + 1;
                $display("wrong value %s exp %h got %h", nm, e, g);
            end
        end
    endtask
    task rc(input [7:0] a, input [7:0] e, input string nm);
        begin
            rd(a);
            chk(nm, e, rd_v);
        end
    endtask
    task wrc(input [7:0] a, input [7:0] d, input [7:0] e);
        begin
            wr(a, d);
            rc(a, e, "readback");
        end
    endtask
    task done(input string s);
        $display("test %s finished", s);
    endtask
    // Event levels for c cycles, then a settle gap
    task ev(input [3:0] d, input [3:0] b, input [3:0] u, input integer c);
        begin
            data_err <= d;
            buf_err <= b;
            buf_under <= u;
            repeat (c) @(posedge clk);
            data_err <= 4'h0;
            buf_err <= 4'h0;
            buf_under <= 4'h0;
            repeat (3) @(posedge clk);
        end
    endtask
    task t_reset;
        begin
            for (i = 8'h0e; i < 8'h21; i = i + 1)
                rc(i[7:0], 8'h00, "reset value");
            chk("load copy", 8'h00, {4'h0, lane_cfg_ff});
            done("reset");
        end
    endtask
    task t_regs;
        begin
            wrc(8'h10, 8'hff, 8'hbf);
            wrc(8'h11, 8'ha5, 8'ha5);
            wrc(8'h12, 8'h5a, 8'h5a);
            wrc(8'h13, 8'hff, 8'h0f);
            wrc(8'h14, 8'hfd, 8'h05);
            chk("threshold", 8'h05, {5'h0, threshold_ff});
            wrc(8'h16, 8'hff, 8'hf7);
            wrc(8'h15, 8'h07, 8'h07);
            wrc(8'h20, 8'hff, 8'h00);
            for (i = 8'h10; i < 8'h17; i = i + 1)
                wr(i[7:0], 8'h00);
            deskew_in <= 1'b1;
            repeat (3) @(posedge clk);
            rc(8'h15, 8'h80, "deskew");
            deskew_in <= 1'b0;
            repeat (3) @(posedge clk);
            rc(8'h15, 8'h00, "deskew");
            done("registers");
        end
    endtask
    task t_count;
        begin
            wr(8'h16, 8'h10);
            ev(4'hf, 4'h0, 4'h0, 5);
            rc(8'h18, 8'h05, "lane0 count");
            rc(8'h1a, 8'h00, "lane1 count");
            rc(8'h17, 8'h10, "flags");
            wr(8'h15, 8'h08);
            rc(8'h17, 8'h00, "flags");
            wr(8'h15, 8'h10);
            repeat (3) @(posedge clk);
            rc(8'h18, 8'h00, "lane0 count");
            ev(4'h1, 4'h0, 4'h0, 3);
            rc(8'h18, 8'h03, "lane0 count");
            wr(8'h15, 8'h00);
            wr(8'h16, 8'h21);
            ev(4'hd, 4'h2, 4'hd, 3);
            rc(8'h1a, 8'h03, "lane1 count");
            wr(8'h16, 8'h43);
            ev(4'h0, 4'h0, 4'h4, 2);
            rc(8'h1c, 8'h02, "lane2 count");
            wr(8'h16, 8'h80);
            ev(4'h8, 4'h0, 4'h0, 4100);
            rc(8'h1e, 8'hff, "lane3 low");
            rc(8'h1f, 8'h0f, "lane3 high");
            wr(8'h16, 8'h14);
            deskew_in <= 1'b1;
            repeat (4) @(posedge clk);
            deskew_in <= 1'b0;
            repeat (3) @(posedge clk);
            rc(8'h18, 8'h07, "lane0 deskew count");
            wr(8'h16, 8'h00);
            done("counters");
        end
    endtask
    // Any window of one full period holds exactly one 8 UI pulse
    task t_sync(input [2:0] len, input integer per);
        begin
            wr(8'h10, {2'b00, len, 3'h4});
            wr(8'h0e, 8'h01);
            wr(8'h0e, 8'h00);
            repeat (300) @(posedge clk);
            cfg_addr <= 8'h0e;
            cfg_rd <= 1'b1;
            @(posedge clk);
            n = 0;
            for (i = 0; i < per; i = i + 1) begin
                @(posedge clk);
                n = n + cfg_rdata_ff[4];
            end
            cfg_rd <= 1'b0;
            @(posedge clk);
            chk("sync count", 8'h08, n[7:0]);
            rd(8'h0f);
            chk("mismatch", 8'h00, rd_v & 8'h10);
            done("sync");
        end
    endtask
    task t_clock;
        begin
            // Toggle first so the lane trains on live data
            tog <= 1'b1;
            wr(8'h15, 8'h01);
            wr(8'h10, 8'h02);
            wr(8'h0e, 8'h01);
            wr(8'h0e, 8'h00);
            wr(8'h10, 8'h04);
            repeat (40) @(posedge clk);
            wr(8'h15, 8'h09);
            rd(8'h0f);
            chk("search", 8'h00, rd_v & 8'h01);
            rc(8'h17, 8'h00, "flags");
            tog <= 1'b0;
            repeat (10) @(posedge clk);
            rd(8'h17);
            chk("flags", 8'h10, rd_v & 8'h10);
            done("clock pattern");
        end
    endtask
    task final_report;
        begin
            $display("checks %0d mismatches %0d", checked, err_count);
            if (err_count == 0 && checked > 0)
                $display("Regression OK");
            else
                $display("Regression broken");
            $finish;
        end
    endtask
    // Tests need about 40k cycles; a hang is cut at 60k
    initial begin
        #(50 * 60000);
        err_count = err_count + 1;
        final_report;
    end
    initial begin
        repeat (10) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        t_reset;
        t_regs;
        t_count;
        t_sync(3'h0, 127);
        t_sync(3'h1, 2047);
        t_sync(3'h4, 32767);
        t_clock;
        final_report;
    end
endmodule
